// file: verilog/slcr_link_config_regs.sv
// Link configuration register slice: receiver capability 2, link
// detect timeout, scratch registers, remote interrupt routing and
// split-image line width.
// Assumes a byte register port on mclk from the serial target engine
// and port select, capability 1 bits and back-channel inputs on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "slcr_regs.svh"
module slcr_link_config_regs #(
    parameter int unsigned LDET_CYC0 = `SLCR_T0_NS / `SLCR_CLK_NS, // 162 ms
    parameter int unsigned LDET_CYC1 = `SLCR_T1_NS / `SLCR_CLK_NS, // 325 ms
    parameter int unsigned LDET_CYC2 = `SLCR_T2_NS / `SLCR_CLK_NS, // 650 ms
    parameter int unsigned LDET_CYC3 = `SLCR_T3_NS / `SLCR_CLK_NS, // 1.3 ms
    parameter int unsigned LDET_CYC6 = `SLCR_T6_NS / `SLCR_CLK_NS, // 41 us
    parameter int unsigned LDET_CYC7 = `SLCR_T7_NS / `SLCR_CLK_NS, // 82 us
    parameter int unsigned LDET_CW   = 26
) (
    input  wire logic       mclk,                 // 100 MHz clock
    input  wire logic       arst_n,               // Async reset
    input  wire logic [7:0] reg_addr,             // Register offset
    input  wire logic [7:0] reg_wdata,            // Write data
    input  wire logic       reg_wr,               // Write strobe
    input  wire logic       reg_rd,               // Read strobe
    output logic      [7:0] reg_rdata,            // Read data
    input  wire logic [1:0] port_sel,             // Port select bits
    input  wire logic [1:0] capability_lock,      // Per-port lock
    input  wire logic [1:0] fcc_mode_lsb,         // Per-port mode bit 0
    input  wire logic [1:0] bcc_cap_load,         // Auto-load pulse
    input  wire logic [1:0] bcc_crc_en,           // Loaded CRC bit
    input  wire logic [3:0] bcc_mode_hi,          // Loaded mode bits
    input  wire logic       single_link,          // Single-link device
    input  wire logic       rc_valid,             // Reverse traffic seen
    input  wire logic [1:0] port_rirq,            // Port remote irqs
    output logic      [1:0] enhanced_crc_enable,  // Per-port CRC mode
    output logic      [5:0] fast_control_channel_mode, // 3 bits/port
    output logic      [1:0] fcc_hs_gpio,          // HS GPIO mode
    output logic      [5:0] fcc_gpio_count,       // GPIOs, 3 bits/port
    output logic      [1:0] fcc_fwd_spi,          // Forward SPI mode
    output logic      [1:0] fcc_rev_spi,          // Reverse SPI mode
    output logic            link_detect,          // Link detected
    output logic            remote_irq_pin,       // Remote irq pin
    output logic            main_irq_pin,         // Main irq share
    output logic      [3:0] gpio_irq,             // Irq on GPIO pins
    output logic      [3:0] aux_gpio_pin,         // Irq on aux pins
    output logic     [12:0] split_line_width      // Line size, pixels
);
    // ------------------------------------------------------------
    // Register state
    // ------------------------------------------------------------
    logic            crc_reg    [2];
    logic      [1:0] modehi_reg [2];
    logic      [2:0] mode_reg   [2];
    logic      [2:0] ldet_reg;
    logic      [7:0] mbox_a_reg;
    logic      [7:0] mbox_b_reg;
    logic      [3:0] iroute_reg;
    logic      [7:0] lw_lo_reg;
    logic      [4:0] lw_hi_reg;
    logic      [7:0] rdata_next;
    logic            rd_port;
    logic      [7:0] cap2_view;

    // Codes 4 and 5 are fixed counts; the lower bound of 11 fits code 4 (1025) but not code 5 (2050)
    if (LDET_CW < 11 || LDET_CW > 31)
        $error("slcr_link_config_regs: LDET_CW out of range");

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = reg_wr && a == off;
    endfunction

    // ------------------------------------------------------------
    // Fast control channel mode decode
    // ------------------------------------------------------------
    function automatic slcr_pkg::slcr_fcc_kind_e fcc_kind(
        input slcr_pkg::slcr_mode_t m);
        case (m)
            3'h0:    fcc_kind = slcr_pkg::FCC_NORMAL;
            3'h1,
            3'h2,
            3'h3:    fcc_kind = slcr_pkg::FCC_HS_GPIO;
            3'h6:    fcc_kind = slcr_pkg::FCC_FWD_SPI;
            3'h7:    fcc_kind = slcr_pkg::FCC_REV_SPI;
            default: fcc_kind = slcr_pkg::FCC_RSVD;
        endcase
    endfunction

    function automatic logic [2:0] gpio_count(input slcr_pkg::slcr_mode_t m);
        case (m)
            3'h1:    gpio_count = 3'h1;
            3'h2:    gpio_count = 3'h2;
            3'h3:    gpio_count = 3'h4;
            default: gpio_count = 3'h0;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Per-port capability 2 and mode outputs
    // ------------------------------------------------------------
    for (genvar p = 0; p < 2; p++) begin : g_port
        logic                  wr_cap;
        slcr_pkg::slcr_mode_t  full_mode;
        slcr_pkg::slcr_mode_t  eff_mode;
        slcr_pkg::slcr_fcc_kind_e kind;

        assign wr_cap    = hit(reg_addr, `SLCR_A_CAP2) && port_sel[p];
        assign full_mode = {modehi_reg[p], fcc_mode_lsb[p]};
        // Single-link parts cannot carry high-speed frames at all
        assign eff_mode  = single_link ? 3'h0 : full_mode;
        assign kind      = fcc_kind(eff_mode);

        // Back-channel load wins a same-cycle write unless locked
        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                crc_reg[p]    <= 1'b0;
                modehi_reg[p] <= 2'h0;
            end else if (bcc_cap_load[p] && !capability_lock[p]) begin
                crc_reg[p]    <= bcc_crc_en[p];
                modehi_reg[p] <= bcc_mode_hi[2*p +: 2];
            end else if (wr_cap) begin
                crc_reg[p]    <= reg_wdata[`SLCR_B_CRC];
                modehi_reg[p] <= reg_wdata[`SLCR_F_MODEHI];
            end
        end

        always_ff @(posedge mclk or negedge arst_n) begin
            if (!arst_n) begin
                mode_reg[p]    <= 3'h0;
                fcc_hs_gpio[p] <= 1'b0;
                fcc_fwd_spi[p] <= 1'b0;
                fcc_rev_spi[p] <= 1'b0;
                fcc_gpio_count[3*p +: 3] <= 3'h0;
            end else begin
                mode_reg[p]    <= eff_mode;
                fcc_hs_gpio[p] <= kind == slcr_pkg::FCC_HS_GPIO;
                fcc_fwd_spi[p] <= kind == slcr_pkg::FCC_FWD_SPI;
                fcc_rev_spi[p] <= kind == slcr_pkg::FCC_REV_SPI;
                fcc_gpio_count[3*p +: 3] <= gpio_count(eff_mode);
            end
        end

        assign enhanced_crc_enable[p]           = crc_reg[p];
        assign fast_control_channel_mode[3*p +: 3] = mode_reg[p];
    end

    // ------------------------------------------------------------
    // Shared registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            ldet_reg <= 3'h0;
        end else if (hit(reg_addr, `SLCR_A_LDET)) begin
            ldet_reg <= reg_wdata[`SLCR_F_LDET];
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            mbox_a_reg <= `SLCR_R_MBOXA;
            mbox_b_reg <= `SLCR_R_MBOXB;
        end else begin
            if (hit(reg_addr, `SLCR_A_MBOXA))
                mbox_a_reg <= reg_wdata;
            if (hit(reg_addr, `SLCR_A_MBOXB))
                mbox_b_reg <= reg_wdata;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            iroute_reg <= 4'h0;
        end else if (hit(reg_addr, `SLCR_A_IROUTE)) begin
            iroute_reg <= reg_wdata[`SLCR_F_IROUTE];
        end
    end

    // No range clamp: widths beyond 4096 are left to software
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            lw_lo_reg <= `SLCR_R_LWLO;
            lw_hi_reg <= `SLCR_R_LWHI;
        end else begin
            if (hit(reg_addr, `SLCR_A_LWLO))
                lw_lo_reg <= reg_wdata;
            if (hit(reg_addr, `SLCR_A_LWHI))
                lw_hi_reg <= reg_wdata[`SLCR_F_LWHI];
        end
    end

    // One width feeds both splitting and dual-input left/right modes
    assign split_line_width = {lw_hi_reg, lw_lo_reg};

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    // Port 1 is shown only when it alone is selected
    assign rd_port   = port_sel == 2'h2;
    assign cap2_view = rd_port
        ? {4'h0, crc_reg[1], 1'b0, modehi_reg[1]}
        : {4'h0, crc_reg[0], 1'b0, modehi_reg[0]};

    always_comb begin
        case (reg_addr)
            `SLCR_A_CAP2:   rdata_next = cap2_view;
            `SLCR_A_LDET:   rdata_next = {5'h0, ldet_reg};
            `SLCR_A_MBOXA:  rdata_next = mbox_a_reg;
            `SLCR_A_MBOXB:  rdata_next = mbox_b_reg;
            `SLCR_A_IROUTE: rdata_next = {4'h0, iroute_reg};
            `SLCR_A_LWLO:   rdata_next = lw_lo_reg;
            `SLCR_A_LWHI:   rdata_next = {3'h0, lw_hi_reg};
            default:        rdata_next = `SLCR_R_ZERO;
        endcase
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            reg_rdata <= `SLCR_R_ZERO;
        end else if (reg_rd) begin
            reg_rdata <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // Link detect and interrupt routing
    // ------------------------------------------------------------
    slcr_link_timer #(
        .CNT0 (LDET_CYC0),
        .CNT1 (LDET_CYC1),
        .CNT2 (LDET_CYC2),
        .CNT3 (LDET_CYC3),
        .CNT4 (`SLCR_T4_NS / `SLCR_CLK_NS),
        .CNT5 (`SLCR_T5_NS / `SLCR_CLK_NS),
        .CNT6 (LDET_CYC6),
        .CNT7 (LDET_CYC7),
        .CW   (LDET_CW)
    ) u_timer (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .sel      (ldet_reg),
        .rc_valid (rc_valid),
        .det      (link_detect)
    );

    slcr_irq_route u_irq (
        .mclk     (mclk),
        .arst_n   (arst_n),
        .route    (iroute_reg),
        .rirq     (port_rirq),
        .rem_irq  (remote_irq_pin),
        .main_irq (main_irq_pin),
        .gpio_irq (gpio_irq),
        .aux_irq  (aux_gpio_pin)
    );

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!arst_n);

    sequence mbox_a_wr_s;
        reg_wr && reg_addr == `SLCR_A_MBOXA;
    endsequence
    sequence mbox_a_rd_s;
        reg_rd && !reg_wr && reg_addr == `SLCR_A_MBOXA;
    endsequence

    // A second scratch write in the gap would make the echo stale
    mbox_echo_a: assert property (
        mbox_a_wr_s ##1 !(reg_wr && reg_addr == `SLCR_A_MBOXA) ##1 mbox_a_rd_s
        |=> reg_rdata == $past(reg_wdata, 3))
        else $error("scratch read differs from write");

    crc_write_a: assert property (
        reg_wr && reg_addr == `SLCR_A_CAP2 && port_sel == 2'h1 && !bcc_cap_load[0]
        |=> enhanced_crc_enable[0] == $past(reg_wdata[`SLCR_B_CRC]))
        else $error("crc enable not written");

    port_map_a: assert property (
        reg_wr && reg_addr == `SLCR_A_CAP2 && port_sel == 2'h2 && !bcc_cap_load[0]
        |=> $stable(enhanced_crc_enable[0]))
        else $error("unselected port written");

    lock_hold_a: assert property (
        capability_lock[0] && bcc_cap_load[0] && !(reg_wr && port_sel[0])
        |=> $stable(enhanced_crc_enable[0]))
        else $error("locked capabilities reloaded");

    single_link_a: assert property (
        single_link [*2] |-> fast_control_channel_mode[2:0] == 3'h0
                             && fcc_gpio_count[2:0] == 3'h0)
        else $error("high speed mode on single link");

    rev_spi_a: assert property (
        fcc_rev_spi[0] |-> fast_control_channel_mode[2:0] == 3'h7 && !fcc_hs_gpio[0])
        else $error("reverse spi decode wrong");

    ldet_rise_a: assert property (
        rc_valid |=> link_detect [*2] or (link_detect ##1 rc_valid))
        else $error("link detect not raised");

    rsvd_read_a: assert property (
        reg_rd && reg_addr == `SLCR_A_LWHI |=> reg_rdata[`SLCR_F_RSVHI] == 3'h0)
        else $error("reserved bits read nonzero");

    width_hi_a: assert property (
        reg_wr && reg_addr == `SLCR_A_LWHI
        |=> split_line_width[12:8] == $past(reg_wdata[`SLCR_F_LWHI]))
        else $error("width high bits not stored");

    width_lo_a: assert property (
        reg_wr && reg_addr == `SLCR_A_LWLO
        |=> split_line_width[7:0] == $past(reg_wdata))
        else $error("width low bits not stored");

    load_wins_a: assert property (
        bcc_cap_load[1] && !capability_lock[1]
        |=> enhanced_crc_enable[1] == $past(bcc_crc_en[1]))
        else $error("unlocked capabilities not loaded");

    sequence cap1_rd_s;
        reg_rd && reg_addr == `SLCR_A_CAP2 && port_sel == 2'h2;
    endsequence
    cap1_read_a: assert property (
        cap1_rd_s |=> reg_rdata[3] == $past(enhanced_crc_enable[1])
                      && reg_rdata[7:4] == 4'h0 && !reg_rdata[2])
        else $error("port 1 capability read wrong");

    hs_count_a: assert property (
        fcc_hs_gpio[0] |-> fcc_gpio_count[2:0] != 3'h0
                           && !fcc_fwd_spi[0] && !fcc_rev_spi[0])
        else $error("high speed gpio decode wrong");
endmodule
`default_nettype wire

// file: verilog/slcr_regs.svh
// Offsets, reset values, field positions and timing figures of the
// link configuration register slice.
// Assumes byte-wide registers on an 8-bit register address.
`ifndef SLCR_REGS_SVH
`define SLCR_REGS_SVH

`define SLCR_A_CAP2    8'h21
`define SLCR_A_LDET    8'h26
`define SLCR_A_MBOXA   8'h2e
`define SLCR_A_MBOXB   8'h2f
`define SLCR_A_IROUTE  8'h30
`define SLCR_A_LWLO    8'h32
`define SLCR_A_LWHI    8'h33

`define SLCR_R_MBOXA   8'ha5
`define SLCR_R_MBOXB   8'h5a
`define SLCR_R_LWLO    8'h00
`define SLCR_R_LWHI    5'h05
`define SLCR_R_ZERO    8'h00

`define SLCR_B_CRC     3
`define SLCR_F_MODEHI  1:0
`define SLCR_F_LDET    2:0
`define SLCR_F_IROUTE  3:0
`define SLCR_F_LWHI    4:0
`define SLCR_F_RSVHI   7:5
`define SLCR_B_IR_PIN  3
`define SLCR_B_IR_AUX  2
`define SLCR_F_IR_IDX  1:0
`define SLCR_IR_OFF    4'h0
`define SLCR_IR_SPLIT  4'h1

`define SLCR_CLK_NS    10
`define SLCR_T0_NS     162000000
`define SLCR_T1_NS     325000000
`define SLCR_T2_NS     650000000
`define SLCR_T3_NS     1300000
`define SLCR_T4_NS     10250
`define SLCR_T5_NS     20500
`define SLCR_T6_NS     41000
`define SLCR_T7_NS     82000

`endif

// file: verilog/slcr_pkg.sv
// Types shared by the link configuration register slice.
// Assumes nothing of its surroundings.
package slcr_pkg;
    typedef logic [2:0] slcr_mode_t;
    typedef enum logic [2:0] {
        FCC_NORMAL,
        FCC_HS_GPIO,
        FCC_RSVD,
        FCC_FWD_SPI,
        FCC_REV_SPI
    } slcr_fcc_kind_e;
    typedef enum logic [2:0] {
        IRQ_OFF,
        IRQ_SPLIT,
        IRQ_RSVD,
        IRQ_GPIO,
        IRQ_AUX
    } slcr_route_e;
endpackage

// file: verilog/slcr_link_timer.sv
// Reverse-channel link detect timer.
// Assumes rc_valid is a one-cycle pulse on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "slcr_regs.svh"
module slcr_link_timer #(
    parameter int unsigned CNT0 = 1,
    parameter int unsigned CNT1 = 1,
    parameter int unsigned CNT2 = 1,
    parameter int unsigned CNT3 = 1,
    parameter int unsigned CNT4 = 1,
    parameter int unsigned CNT5 = 1,
    parameter int unsigned CNT6 = 1,
    parameter int unsigned CNT7 = 1,
    parameter int unsigned CW   = 26
) (
    input  wire logic       mclk,     // Clock
    input  wire logic       arst_n,   // Async reset
    input  wire logic [2:0] sel,      // Timeout selection
    input  wire logic       rc_valid, // Valid reverse traffic
    output logic            det       // Link detected
);
    if (CNT0 >= 2**CW || CNT1 >= 2**CW || CNT2 >= 2**CW || CNT3 >= 2**CW)
        $error("slcr_link_timer: CW too small");

    logic [CW-1:0] cnt_reg;
    logic [CW-1:0] lim;
    logic          det_reg;

    function automatic logic [CW-1:0] limit(input logic [2:0] s);
        case (s)
            3'h0:    limit = CW'(CNT0);
            3'h1:    limit = CW'(CNT1);
            3'h2:    limit = CW'(CNT2);
            3'h3:    limit = CW'(CNT3);
            3'h4:    limit = CW'(CNT4);
            3'h5:    limit = CW'(CNT5);
            3'h6:    limit = CW'(CNT6);
            default: limit = CW'(CNT7);
        endcase
    endfunction

    assign lim = limit(sel);

    // Counter saturates so a dead link never wraps back to detected
    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            cnt_reg <= '0;
        end else if (rc_valid) begin
            cnt_reg <= '0;
        end else if (cnt_reg < lim) begin
            cnt_reg <= cnt_reg + 1'b1;
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            det_reg <= 1'b0;
        end else if (rc_valid) begin
            det_reg <= 1'b1;
        end else if (cnt_reg >= lim) begin
            det_reg <= 1'b0;
        end
    end

    assign det = det_reg;

    ldet_expire_a: assert property (@(posedge mclk) disable iff (!arst_n)
        (cnt_reg >= lim && !rc_valid) |=> !det_reg)
        else $error("link detect held after timeout");
endmodule
`default_nettype wire

// file: verilog/slcr_irq_route.sv
// Remote interrupt routing onto the interrupt and GPIO pins.
// Assumes both port interrupts are active-high levels on mclk.
`timescale 1ns/1ps
`default_nettype none
`include "slcr_regs.svh"
module slcr_irq_route (
    input  wire logic       mclk,         // Clock
    input  wire logic       arst_n,       // Async reset
    input  wire logic [3:0] route,        // Routing code
    input  wire logic [1:0] rirq,         // Per-port remote irq
    output logic            rem_irq,      // Remote irq pin level
    output logic            main_irq,     // Main irq pin share
    output logic [3:0]      gpio_irq,     // Onto GPIO pins
    output logic [3:0]      aux_irq       // Onto aux GPIO pins
);
    slcr_pkg::slcr_route_e kind;
    logic                  comb;
    logic [3:0]            gpio_next;
    logic [3:0]            aux_next;

    function automatic slcr_pkg::slcr_route_e route_kind(input logic [3:0] m);
        if (m == `SLCR_IR_OFF)
            route_kind = slcr_pkg::IRQ_OFF;
        else if (m == `SLCR_IR_SPLIT)
            route_kind = slcr_pkg::IRQ_SPLIT;
        else if (!m[`SLCR_B_IR_PIN])
            route_kind = slcr_pkg::IRQ_RSVD;
        else if (m[`SLCR_B_IR_AUX])
            route_kind = slcr_pkg::IRQ_AUX;
        else
            route_kind = slcr_pkg::IRQ_GPIO;
    endfunction

    assign kind = route_kind(route);
    assign comb = |rirq;

    for (genvar i = 0; i < 4; i++) begin : g_pin
        assign gpio_next[i] = comb && kind == slcr_pkg::IRQ_GPIO
                              && route[`SLCR_F_IR_IDX] == 2'(i);
        assign aux_next[i]  = comb && kind == slcr_pkg::IRQ_AUX
                              && route[`SLCR_F_IR_IDX] == 2'(i);
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            rem_irq  <= 1'b0;
            main_irq <= 1'b0;
        end else begin
            case (kind)
                slcr_pkg::IRQ_SPLIT: begin
                    rem_irq  <= rirq[0];
                    main_irq <= rirq[1];
                end
                default: begin
                    rem_irq  <= 1'b0;
                    main_irq <= 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge mclk or negedge arst_n) begin
        if (!arst_n) begin
            gpio_irq <= 4'h0;
            aux_irq  <= 4'h0;
        end else begin
            gpio_irq <= gpio_next;
            aux_irq  <= aux_next;
        end
    end

    split_route_a: assert property (@(posedge mclk) disable iff (!arst_n)
        route == `SLCR_IR_SPLIT |=> rem_irq == $past(rirq[0])
                                   && main_irq == $past(rirq[1]))
        else $error("split routing mismatch");
    gpio_route_a: assert property (@(posedge mclk) disable iff (!arst_n)
        route == 4'h9 |=> gpio_irq[1] == $past(|rirq) && aux_irq == 4'h0)
        else $error("gpio routing mismatch");
    off_route_a: assert property (@(posedge mclk) disable iff (!arst_n)
        route == `SLCR_IR_OFF |=> !rem_irq && gpio_irq == 4'h0 && aux_irq == 4'h0)
        else $error("disabled routing drives a pin");
endmodule
`default_nettype wire

// file: bench/slcr_host_model.sv
// Host controller model on the byte register port.
// Assumes the bench calls its tasks; it moves strobes on falling mclk.
`timescale 1ns/1ps
`default_nettype none
module slcr_host_model (
    input  wire logic       mclk,      // Clock
    output logic      [7:0] reg_addr,  // Offset
    output logic      [7:0] reg_wdata, // Write data
    output logic            reg_wr,    // Write strobe
    output logic            reg_rd,    // Read strobe
    input  wire logic [7:0] reg_rdata  // Read data
);
    initial begin
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // Data flips once released, so a stale byte is never mistaken as held
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge mclk);
        reg_wr = 1'b0;
        reg_wdata = ~d;
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge mclk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge mclk);
        reg_rd = 1'b0;
        d = reg_rdata;
    endtask
endmodule
`default_nettype wire

// file: bench/serializer_link_config_regs_tb_top.sv
// Self-checking bench for the link configuration register slice.
// Assumes the host model drives the register port; small timer counts.
`timescale 1ns/1ps
`default_nettype none
module serializer_link_config_regs_tb_top;
    logic mclk, arst_n, wr, rd, single_link, rc_valid;
    logic [7:0] addr, wdata, rdata, d;
    logic [1:0] port_sel, lsb, rirq, crc, hs, fw, rv, lock, ld, bcrc;
    logic [5:0] mode, cnt;
    logic [3:0] gpio, aux, c, bmode;
    logic rem, mn, det;
    logic [12:0] width;
    int err_count, n_checks, cyc;
    int mdl [256];
    int adr [7] = '{8'h21, 8'h26, 8'h2e, 8'h2f, 8'h30, 8'h32, 8'h33};
    int gcnt [8] = '{0, 1, 2, 4, 0, 0, 0, 0};
    slcr_link_config_regs #(.LDET_CYC0(20), .LDET_CYC1(30), .LDET_CYC2(40),
        .LDET_CYC3(50), .LDET_CYC6(60), .LDET_CYC7(70)) u_slcr_link_config_regs (
        .mclk(mclk), .arst_n(arst_n), .reg_addr(addr), .reg_wdata(wdata),
        .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata), .port_sel(port_sel),
        .capability_lock(lock), .fcc_mode_lsb(lsb), .bcc_cap_load(ld),
        .bcc_crc_en(bcrc), .bcc_mode_hi(bmode), .single_link(single_link),
        .rc_valid(rc_valid), .port_rirq(rirq), .enhanced_crc_enable(crc),
        .fast_control_channel_mode(mode), .fcc_hs_gpio(hs), .fcc_gpio_count(cnt),
        .fcc_fwd_spi(fw), .fcc_rev_spi(rv), .link_detect(det),
        .remote_irq_pin(rem), .main_irq_pin(mn), .gpio_irq(gpio),
        .aux_gpio_pin(aux), .split_line_width(width));
    slcr_host_model u_slcr_host_model (.mclk(mclk), .reg_addr(addr),
        .reg_wdata(wdata), .reg_wr(wr), .reg_rd(rd), .reg_rdata(rdata));
    function automatic int msk(int a);
        case (a)
            8'h21: return 8'h0b;
            8'h26: return 8'h07;
            8'h30: return 8'h0f;
            8'h33: return 8'h1f;
            8'h2e, 8'h2f, 8'h32: return 8'hff;
            default: return 0;
        endcase
    endfunction
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        n_checks++;
        if (g !== e) begin
            err_count++;
            $display("mismatch %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic rchk(input int a);
        u_slcr_host_model.rd(a[7:0], d);
        chk($sformatf("reg %h", a), mdl[a], {8'h00, d});
    endtask
    task automatic complete_run();
        $display("checks %0d errors %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_count++;
            complete_run();
        end
    end
    initial begin
        {arst_n, single_link, rc_valid, lsb, rirq, lock, ld, bcrc, bmode} = '0;
        port_sel = 2'b01;
        mdl = '{default: 0};
        mdl[8'h2e] = 8'ha5;
        mdl[8'h2f] = 8'h5a;
        mdl[8'h33] = 8'h05;
        void'($urandom(32'h0e01));
        repeat (16) @(posedge mclk);
        @(negedge mclk) arst_n = 1'b1;
        chk("width", 13'h500, width);
        foreach (adr[i]) rchk(adr[i]);
        rchk(8'h22);
        foreach (adr[i]) begin
            d = $urandom;
            if (adr[i] == 8'h33) d &= 8'h0f;
            u_slcr_host_model.wr(adr[i][7:0], d);
            mdl[adr[i]] = d & msk(adr[i]);
            rchk(adr[i]);
        end
        chk("width", {mdl[8'h33][4:0], mdl[8'h32][7:0]}, width);
        chk("crc", mdl[8'h21][3], crc[0]);
        port_sel = 2'b10;
        u_slcr_host_model.rd(8'h21, d);
        chk("cap port1", 0, d);
        u_slcr_host_model.wr(8'h21, 8'hff);
        u_slcr_host_model.rd(8'h21, d);
        chk("cap port1", 8'h0b, d);
        port_sel = 2'b01;
        rchk(8'h21);
        for (int m = 0; m < 9; m++) begin
            single_link = (m == 8);
            lsb = {1'b0, m[0]};
            u_slcr_host_model.wr(8'h21, {6'h00, m[2:1]});
            repeat (2) @(negedge mclk);
            chk("mode", (m == 8) ? 0 : m, mode[2:0]);
            chk("hs", m > 0 && m < 4, hs[0]);
            chk("gcnt", gcnt[m % 8], cnt[2:0]);
            chk("spi", {m == 6, m == 7}, {fw[0], rv[0]});
        end
        {bcrc, bmode, lock} = 8'h59;
        @(negedge mclk) ld = 2'b11;
        @(negedge mclk) ld = 2'b00;
        u_slcr_host_model.rd(8'h21, d);
        chk("cap lock", 8'h00, d);
        port_sel = 2'b10;
        u_slcr_host_model.rd(8'h21, d);
        chk("cap load", 8'h01, d);
        lock = 2'b00;
        @(negedge mclk) ld = 2'b01;
        @(negedge mclk) ld = 2'b00;
        port_sel = 2'b01;
        u_slcr_host_model.rd(8'h21, d);
        chk("cap load", 8'h0a, d);
        chk("crc", 2'b01, crc);
        for (int k = 0; k < 16; k++) begin
            c = k;
            rirq = $urandom;
            u_slcr_host_model.wr(8'h30, {4'h0, c});
            repeat (2) @(negedge mclk);
            chk("irq", {(c == 1) & rirq[0], (c == 1) & rirq[1]}, {rem, mn});
            chk("gpio", (c[3:2] == 2 && |rirq) ? 4'h1 << c[1:0] : 0, gpio);
            chk("aux", (c[3:2] == 3 && |rirq) ? 4'h1 << c[1:0] : 0, aux);
        end
        u_slcr_host_model.wr(8'h26, 8'h04);
        @(negedge mclk) rc_valid = 1'b1;
        @(negedge mclk) rc_valid = 1'b0;
        chk("det on", 1, det);
        repeat (1025) @(negedge mclk);
        chk("det hold", 1, det);
        @(negedge mclk);
        chk("det off", 0, det);
        complete_run();
    end
endmodule
`default_nettype wire
